// >>> verilog/sap_host_port.sv
// converter control and parallel host port of the 14-bit converter
`default_nettype none
// Contract
// - standby input high holds the device in standby power-down
// - doze input high puts the device into reduced-power doze
// - convert-start falling edge switches track/hold to hold and starts conversion
// - reset low returns state machine to idle and aborts conversion
// - saturate enable forces over-scale to all ones, under-scale to zeros
// - chip select and read low drive output register onto data lines
// - offset word captured at falling edge of write pulse with select low
// - busy goes low after convert-start edge and stays low while converting
// - mode two: busy rises only after result loads into output register
// - mode one: busy rises at completion; result loads at next start edge
// - fourteen data lines, highest is msb, direction set by select and strobes
// - fifteenth output line carries the overrange bit
// - results are straight binary, lsb is reference over 16384
module sap_host_port
    import sap_pkg::*;
#(
    parameter logic [1:0] MODE_B_SEL = MODE_B_SEL_DEF
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             standby_request,
    input  wire logic             doze_request,
    input  wire logic             sample_start_n,
    input  wire logic             interface_variant_a,
    input  wire logic             interface_variant_b,
    input  wire logic             saturate_enable,
    input  wire logic             cs_n,
    input  wire logic             rd_n,
    input  wire logic             write_strobe,
    input  wire logic [RES_W-1:0] result_lines_in,
    input  wire logic             comp_above,
    output logic [RES_W-1:0]      result_lines_out,
    output logic                  result_lines_oe,
    output logic                  overrange_line,
    output logic                  overrange_oe,
    output logic                  busy_n,
    output logic                  hold_active,
    output logic [RAW_W-1:0]      dac_code,
    output logic                  standby_active,
    output logic                  doze_active,
    output logic                  doze_settled,
    output logic [OFS_W-1:0]      offset_word
);
    typedef struct packed {
        sap_state_t              st;
        logic                    start_n_prev;
        logic                    write_prev;
        logic                    cs_at_write;
        logic [RES_W-1:0]        out_reg;
        logic                    out_ovr;
        logic [RES_W-1:0]        pend_reg;
        logic                    pend_ovr;
        logic                    pend_valid;
        logic [OFS_W-1:0]        offset;
        logic                    busy_n;
        logic                    hold;
        logic                    drive;
        logic [RES_W-1:0]        drive_data;
        logic                    drive_ovr;
        logic [RAW_W-1:0]        dac;
        logic                    standby;
        logic                    doze;
        logic [WAKE_CNT_W-1:0]   wake_cnt;
        logic                    settled;
    } sap_top_t;

    localparam sap_top_t TOP_RST = '{
        st:           SAP_ST_IDLE,
        start_n_prev: 1'b1,
        write_prev:   1'b0,
        cs_at_write:  1'b0,
        out_reg:      RESULT_RST,
        out_ovr:      1'b0,
        pend_reg:     RESULT_RST,
        pend_ovr:     1'b0,
        pend_valid:   1'b0,
        offset:       OFFSET_RST,
        busy_n:       BUSY_N_RST,
        hold:         1'b0,
        drive:        1'b0,
        drive_data:   RESULT_RST,
        drive_ovr:    1'b0,
        dac:          '0,
        standby:      1'b0,
        doze:         1'b0,
        wake_cnt:     '0,
        settled:      1'b1
    };

    initial begin
        if ($isunknown(MODE_B_SEL)) begin
            $error("sap_host_port: mode select code must be fully defined");
        end
        if (RAW_W != RES_W + 1) begin
            $error("sap_host_port: raw code must be one bit wider than the result");
        end
        if (OFS_W != RES_W) begin
            $error("sap_host_port: offset word is loaded from the data lines");
        end
        if (FULL_CODES != (1 << RES_W)) begin
            $error("sap_host_port: full scale must span the data lines");
        end
        if (DOZE_WAKE_CYC < 1) begin
            $error("sap_host_port: settle window must last at least one cycle");
        end
        if (DOZE_WAKE_CYC >= (1 << WAKE_CNT_W)) begin
            $error("sap_host_port: wake counter too small");
        end
    end

    sap_top_t          r_r;
    sap_top_t          r_nxt;
    logic              start_edge;
    logic              write_fall;
    logic              mode_b;
    logic              powered_down;
    logic              sar_start;
    logic              sar_done;
    logic [RAW_W-1:0]  sar_code;
    logic [RAW_W-1:0]  sar_trial;
    logic [RES_W-1:0]  fmt_result;
    logic              fmt_ovr;
    logic              read_req;
    logic              write_take;
    logic              conv_end;

    // converter keeps idle and ignores starts while powered down
    assign powered_down = standby_request | doze_request;
    assign start_edge   = r_r.start_n_prev & ~sample_start_n;
    assign write_fall   = r_r.write_prev & ~write_strobe;
    assign mode_b       = ({interface_variant_b, interface_variant_a} == MODE_B_SEL);
    assign sar_start    = start_edge & ~powered_down;
    // a read is any cycle with select and read low while no write pulse is up
    assign read_req     = ~cs_n & ~rd_n & ~write_strobe;
    // the word lands only if select was low in the last high cycle of the pulse
    assign write_take   = write_fall & r_r.cs_at_write;
    // the search finished this cycle and no power-down cut it short
    assign conv_end     = (r_r.st == SAP_ST_CONV) & sar_done & ~powered_down;

    sap_sar_engine #(
        .W (RAW_W)
    ) u_sar (
        .clk        (clk),
        .resetn     (resetn),
        .abort      (powered_down),
        .start      (sar_start),
        .comp_above (comp_above),
        .trial_code (sar_trial),
        .code       (sar_code),
        .done       (sar_done)
    );

    sap_result_format u_fmt (
        .raw_code        (sar_code),
        .offset_word     (r_r.offset),
        .saturate_enable (saturate_enable),
        .result          (fmt_result),
        .overrange       (fmt_ovr)
    );

    always_comb begin
        r_nxt              = r_r;
        r_nxt.start_n_prev = sample_start_n;
        r_nxt.write_prev   = write_strobe;
        r_nxt.dac          = sar_trial;
        r_nxt.standby      = standby_request;
        r_nxt.doze         = doze_request;

        // settle window after doze release, visible to the host
        if (doze_request) begin
            r_nxt.wake_cnt = WAKE_CNT_LOAD;
            r_nxt.settled  = 1'b0;
        end else if (r_r.wake_cnt != '0) begin
            r_nxt.wake_cnt = r_r.wake_cnt - 1'b1;
            r_nxt.settled  = (r_r.wake_cnt == WAKE_CNT_W'(1));
        end

        // select sampled while the write pulse is high; tied-low select just works
        if (write_strobe) begin
            r_nxt.cs_at_write = ~cs_n;
        end
        if (write_take) begin
            r_nxt.offset = result_lines_in;
        end

        // bus drives in the cycle after a read cycle, so a write pulse that rises drops it one cycle later
        r_nxt.drive      = read_req;
        r_nxt.drive_data = r_r.out_reg;
        r_nxt.drive_ovr  = r_r.out_ovr;

        case (r_r.st)
            SAP_ST_IDLE: begin
                r_nxt.hold = 1'b0;
                if (powered_down) begin
                    r_nxt.busy_n = 1'b1;
                end
            end
            SAP_ST_CONV: begin
                r_nxt.busy_n = 1'b0;
                r_nxt.hold   = 1'b1;
                if (powered_down) begin
                    r_nxt.st     = SAP_ST_IDLE;
                    r_nxt.busy_n = 1'b1;
                    r_nxt.hold   = 1'b0;
                end else if (conv_end) begin
                    r_nxt.hold = 1'b0;
                    if (mode_b) begin
                        // result lands first, busy rises one cycle later
                        r_nxt.out_reg    = fmt_result;
                        r_nxt.out_ovr    = fmt_ovr;
                        // a sample left pending by the other mode is stale now
                        r_nxt.pend_valid = 1'b0;
                        r_nxt.st         = SAP_ST_LOAD;
                    end else begin
                        r_nxt.pend_reg   = fmt_result;
                        r_nxt.pend_ovr   = fmt_ovr;
                        r_nxt.pend_valid = 1'b1;
                        r_nxt.busy_n     = 1'b1;
                        r_nxt.st         = SAP_ST_IDLE;
                    end
                end
            end
            SAP_ST_LOAD: begin
                r_nxt.busy_n = 1'b1;
                r_nxt.st     = SAP_ST_IDLE;
            end
            default: begin
                r_nxt.st = SAP_ST_IDLE;
            end
        endcase

        // a start edge wins over everything above: hold, busy low, restart
        if (sar_start) begin
            r_nxt.st     = SAP_ST_CONV;
            r_nxt.hold   = 1'b1;
            r_nxt.busy_n = 1'b0;
            if (!mode_b && r_nxt.pend_valid) begin
                // previous sample becomes readable only now; a search ending in this
                // very cycle counts as the previous sample, so its result is not lost
                r_nxt.out_reg    = r_nxt.pend_reg;
                r_nxt.out_ovr    = r_nxt.pend_ovr;
                r_nxt.pend_valid = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_r <= TOP_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign result_lines_out = r_r.drive_data;
    assign result_lines_oe  = r_r.drive;
    assign overrange_line   = r_r.drive_ovr;
    assign overrange_oe     = r_r.drive;
    assign busy_n           = r_r.busy_n;
    assign hold_active      = r_r.hold;
    assign dac_code         = r_r.dac;
    assign standby_active   = r_r.standby;
    assign doze_active      = r_r.doze;
    assign doze_settled     = r_r.settled;
    assign offset_word      = r_r.offset;
endmodule
`default_nettype wire

// >>> verilog/sap_pkg.sv
// shared constants and types for the converter control and host port
`default_nettype none
package sap_pkg;
    // result geometry
    localparam int RES_W        = 14;
    localparam int RAW_W        = 15;
    localparam int OFS_W        = 14;
    localparam int FULL_CODES   = 16384;
    // mode select: {interface_variant_b, interface_variant_a} selecting mode 2
    localparam logic [1:0] MODE_B_SEL_DEF = 2'h2;
    // reset values and saturation codes
    localparam logic [RES_W-1:0] RESULT_RST = 14'h0000;
    localparam logic [OFS_W-1:0] OFFSET_RST = 14'h0000;
    localparam logic             BUSY_N_RST = 1'h1;
    localparam logic [RES_W-1:0] ALL_ONES   = 14'h3FFF;
    localparam logic [RES_W-1:0] ALL_ZEROS  = 14'h0000;
    // timing
    localparam int CLK_MHZ         = 25;
    localparam int DOZE_WAKE_NS    = 100;
    localparam int DOZE_WAKE_CYC_R = (DOZE_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int DOZE_WAKE_CYC   = (DOZE_WAKE_CYC_R < 1) ? 1 : DOZE_WAKE_CYC_R;
    localparam int WAKE_CNT_W      = 4;
    localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_LOAD = WAKE_CNT_W'(DOZE_WAKE_CYC);

    typedef enum logic [2:0] {
        SAP_ST_IDLE = 3'h1,
        SAP_ST_CONV = 3'h2,
        SAP_ST_LOAD = 3'h4
    } sap_state_t;
endpackage
`default_nettype wire

// >>> verilog/sap_sar_engine.sv
// bit-serial successive-approximation sequencer driving the trial code
`default_nettype none
module sap_sar_engine
    import sap_pkg::*;
#(
    parameter int W = RAW_W
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         abort,
    input  wire logic         start,
    input  wire logic         comp_above,
    output logic [W-1:0]      trial_code,
    output logic [W-1:0]      code,
    output logic              done
);
    initial begin
        if (W < 2 || W > 16) $error("sap_sar_engine: W out of range");
    end

    typedef struct packed {
        logic          running;
        logic [4:0]    idx;
        logic [W-1:0]  acc;
        logic [W-1:0]  code;
        logic          done;
    } sap_sar_t;

    sap_sar_t s_r;
    sap_sar_t s_nxt;
    logic [W-1:0] trial;

    always_comb begin
        trial = s_r.acc | (W'(1) << s_r.idx);
    end

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (abort) begin
            s_nxt.running = 1'b0;
        end else if (start) begin
            // a new start restarts the search from the top bit
            s_nxt.running = 1'b1;
            s_nxt.idx     = 5'(W - 1);
            s_nxt.acc     = '0;
        end else if (s_r.running) begin
            // comparator says input is above the trial level: keep the bit
            if (comp_above) begin
                s_nxt.acc = trial;
            end
            if (s_r.idx == 5'h00) begin
                s_nxt.running = 1'b0;
                s_nxt.done    = 1'b1;
                s_nxt.code    = comp_above ? trial : s_r.acc;
            end else begin
                s_nxt.idx = s_r.idx - 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // the trial leaves through an output register, so the next trial is handed out:
    // the comparator then judges the very trial that the search stands at
    assign trial_code = s_nxt.acc | (W'(1) << s_nxt.idx);
    assign code       = s_r.code;
    assign done       = s_r.done;
endmodule
`default_nettype wire

// >>> verilog/sap_result_format.sv
// offset removal, range check and saturation of a raw conversion code
`default_nettype none
module sap_result_format
    import sap_pkg::*;
(
    input  wire logic [RAW_W-1:0] raw_code,
    input  wire logic [OFS_W-1:0] offset_word,
    input  wire logic             saturate_enable,
    output logic [RES_W-1:0]      result,
    output logic                  overrange
);
    logic signed [RAW_W+1:0] adj;
    logic                    above;
    logic                    below;

    always_comb begin
        // offset word is two's complement; straight binary after removal
        adj   = $signed({2'b00, raw_code}) - $signed({{3{offset_word[OFS_W-1]}}, offset_word});
        below = adj < 0;
        above = adj > $signed((RAW_W+2)'(FULL_CODES - 1));
        if (saturate_enable && above) begin
            result    = ALL_ONES;
            overrange = 1'b0;
        end else if (saturate_enable && below) begin
            result    = ALL_ZEROS;
            overrange = 1'b0;
        end else begin
            result    = adj[RES_W-1:0];
            overrange = above | below;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/sap_host_port_monitor.sv
// assertion checker watching the ports of the converter host port
`default_nettype none
module sap_host_port_monitor
    import sap_pkg::*;
(
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             standby_request,
    input wire logic             doze_request,
    input wire logic             sample_start_n,
    input wire logic             cs_n,
    input wire logic             rd_n,
    input wire logic             write_strobe,
    input wire logic [RES_W-1:0] result_lines_in,
    input wire logic [RES_W-1:0] result_lines_out,
    input wire logic             result_lines_oe,
    input wire logic             overrange_oe,
    input wire logic             busy_n,
    input wire logic             hold_active,
    input wire logic [OFS_W-1:0] offset_word
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic start_q;
    logic taken;
    logic rd_on;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) start_q <= 1'b1;
        else start_q <= sample_start_n;
    end
    assign taken = start_q & ~sample_start_n & ~standby_request & ~doze_request;
    assign rd_on = ~cs_n & ~rd_n & ~write_strobe;
    sequence quiet7;
        (!standby_request && !doze_request)[*7];
    endsequence
    // three settled read cycles, so a load landing just before is not mistaken for a change
    sequence steady3;
        (rd_on && result_lines_oe && busy_n && sample_start_n)[*3];
    endsequence
    a_start_hold: assert property (taken |=> !busy_n && hold_active)
        else $error("busy or hold missing after start edge");
    a_busy_low: assert property (taken ##1 quiet7 |-> !busy_n)
        else $error("busy rose early");
    a_busy_ends: assert property (taken |-> ##[2:20] busy_n)
        else $error("busy never rose");
    a_power_down: assert property (standby_request || doze_request |=> busy_n)
        else $error("converting while powered down");
    a_read_drive: assert property (rd_on |=> result_lines_oe && overrange_oe)
        else $error("data lines not driven on read");
    a_read_release: assert property (!rd_on |=> !result_lines_oe)
        else $error("data lines driven without read");
    a_data_hold: assert property (steady3 |-> $stable(result_lines_out))
        else $error("output word changed without load");
    a_write_capture: assert property ($fell(write_strobe) && !$past(cs_n)
        |=> offset_word == $past(result_lines_in))
        else $error("offset word not captured");
endmodule
`default_nettype wire

// >>> testbench/sap_analog_model.sv
// comparator and shared data-line model for the far side
`default_nettype none
module sap_analog_model
    import sap_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [RAW_W-1:0] level,
    input  wire logic [RAW_W-1:0] dac_code,
    input  wire logic [RES_W-1:0] dev_d,
    input  wire logic             dev_oe,
    input  wire logic [RES_W-1:0] host_d,
    input  wire logic             host_oe,
    output logic                  comp_above,
    output logic [RES_W-1:0]      bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [RES_W-1:0] last_r = 14'h0000;
    // input sits half a step above level, so an equal trial still reads above it
    assign comp_above = (level >= dac_code);
    // an undriven bus shows the inverse of its last value, never a held copy
    assign bus = dev_oe ? dev_d : host_oe ? host_d : ~last_r;
    always @(posedge clk) last_r <= bus;
endmodule
`default_nettype wire

// >>> testbench/sap_host_port_bench.sv
// self-checking bench for the converter host port
`default_nettype none
module sap_host_port_bench
    import sap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk, resetn, standby_request, doze_request, sample_start_n;
    logic             interface_variant_a, interface_variant_b, saturate_enable;
    logic             cs_n, rd_n, write_strobe, comp_above, result_lines_oe, busy_n;
    logic             overrange_line, overrange_oe, hold_active, standby_active;
    logic             doze_active, doze_settled, host_oe, cs_idle;
    logic [RES_W-1:0] bus, result_lines_out, host_d, offset_word;
    logic [RAW_W-1:0] dac_code, level;
    logic [RES_W-1:0] sat_d [4] = '{14'h3FFF, 14'h0005, 14'h0000, 14'h3FF5};
    int               failures, num_checks, cycles;

    sap_host_port u_dut (
        .clk, .resetn, .standby_request, .doze_request, .sample_start_n,
        .interface_variant_a, .interface_variant_b, .saturate_enable, .cs_n, .rd_n,
        .write_strobe, .result_lines_in(bus), .comp_above, .result_lines_out,
        .result_lines_oe, .overrange_line, .overrange_oe, .busy_n, .hold_active,
        .dac_code, .standby_active, .doze_active, .doze_settled, .offset_word
    );
    sap_analog_model u_model (
        .clk, .level, .dac_code, .dev_d(result_lines_out), .dev_oe(result_lines_oe),
        .host_d, .host_oe, .comp_above, .bus
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            $display("unexpected cycle count: expected 3000, seen %0d", cycles);
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic host_read(input logic [RES_W-1:0] d, input logic o);
        @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        // held long enough for three settled driven cycles, so the hold check sees it
        repeat (4) @(negedge clk);
        chk("read oe", 16'h1, result_lines_oe);
        chk("read data", {2'h0, d}, result_lines_out);
        chk("overrange", {15'h0, o}, overrange_line);
        rd_n = 1'b1;
        cs_n = cs_idle;
        repeat (2) @(negedge clk);
        chk("release oe", 16'h0, result_lines_oe);
    endtask

    task automatic host_write(input logic [RES_W-1:0] w);
        @(negedge clk);
        cs_n = 1'b0;
        host_d = w;
        host_oe = 1'b1;
        write_strobe = 1'b1;
        @(negedge clk);
        write_strobe = 1'b0;
        @(negedge clk);
        host_oe = 1'b0;
        cs_n = cs_idle;
        @(negedge clk);
        chk("offset", {2'h0, w}, offset_word);
    endtask

    // level stays put for the whole conversion, as a held input would
    task automatic convert(input logic [RAW_W-1:0] lvl);
        int n;
        level = lvl;
        @(negedge clk);
        sample_start_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("busy_n start", 16'h0, busy_n);
        chk("hold", 16'h1, hold_active);
        sample_start_n = 1'b1;
        n = 0;
        while (busy_n !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("busy_n end", 16'h1, busy_n);
    endtask

    initial begin
        {resetn, standby_request, doze_request, saturate_enable, write_strobe, host_oe} = '0;
        {sample_start_n, cs_n, rd_n, cs_idle} = 4'hF;
        {interface_variant_b, interface_variant_a} = MODE_B_SEL_DEF;
        host_d = 14'h0000;
        level = 15'h0000;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        chk("busy_n", 16'h1, busy_n);
        chk("oe", 16'h0, result_lines_oe);
        $display("test reset done");
        convert(15'h1234);
        host_read(14'h1234, 1'b0);
        host_read(14'h1234, 1'b0);
        $display("test mode b done");
        {interface_variant_b, interface_variant_a} = ~MODE_B_SEL_DEF;
        convert(15'h0555);
        convert(15'h0777);
        host_read(14'h0555, 1'b0);
        {interface_variant_b, interface_variant_a} = MODE_B_SEL_DEF;
        $display("test mode a done");
        cs_idle = 1'b0;
        cs_n = 1'b0;
        host_write(14'h0010);
        convert(15'h0100);
        host_read(14'h00F0, 1'b0);
        cs_idle = 1'b1;
        cs_n = 1'b1;
        $display("test offset done");
        for (int i = 0; i < 4; i++) begin
            host_write(i[1] ? 14'h0010 : 14'h0000);
            saturate_enable = ~i[0];
            convert(i[1] ? 15'h0005 : 15'h4005);
            host_read(sat_d[i], i[0]);
        end
        saturate_enable = 1'b0;
        $display("test saturate done");
        standby_request = 1'b1;
        @(negedge clk);
        sample_start_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("standby busy_n", 16'h1, busy_n);
        chk("standby flag", 16'h1, standby_active);
        sample_start_n = 1'b1;
        standby_request = 1'b0;
        doze_request = 1'b1;
        @(negedge clk);
        sample_start_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("doze busy_n", 16'h1, busy_n);
        chk("doze flag", 16'h1, doze_active);
        sample_start_n = 1'b1;
        doze_request = 1'b0;
        repeat (DOZE_WAKE_CYC + 1) @(negedge clk);
        chk("settled", 16'h1, doze_settled);
        convert(15'h0200);
        host_read(14'h01F0, 1'b0);
        $display("test power done");
        @(negedge clk);
        sample_start_n = 1'b0;
        repeat (5) @(negedge clk);
        resetn = 1'b0;
        sample_start_n = 1'b1;
        @(negedge clk);
        chk("abort busy_n", 16'h1, busy_n);
        chk("abort offset", 16'h0, offset_word);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        chk("after reset busy_n", 16'h1, busy_n);
        chk("after reset hold", 16'h0, hold_active);
        $display("test abort done");
        complete_run();
    end
endmodule

bind sap_host_port sap_host_port_monitor u_mon (
    .clk, .resetn, .standby_request, .doze_request, .sample_start_n, .cs_n, .rd_n,
    .write_strobe, .result_lines_in, .result_lines_out, .result_lines_oe,
    .overrange_oe, .busy_n, .hold_active, .offset_word
);
`default_nettype wire
